// File: src/pss_sequencer.sv
/*
 * Supervisor and power sequencer: rail enables, power-good status,
 * fault flags, lockout sequencing, reset outputs and register port.
 * Assumes analog comparators deliver asynchronous levels, straps are
 * static, and software uses the one-cycle strobe register port.
 */
// Chosen here: strobed register access and the address map.
// Notes on behaviour
// - Low-dropout mode holds high-side switch on
// - Discharge on shutdown only when enabled
// - Buck power-not-good at 10%, 5% hysteresis
// - Status bits plus maskable drop interrupt
// - No monitoring while converter disabled
// - Power-on reset follows main rail good
// - Linear regulators monitored the same way
// - Linear two monitor off when disabled
// - Overtemperature shutdown armed only fixed-frequency
// - Linear regulators on after reset
// - Undervoltage threshold 2.75 V, software writable
// - Undervoltage: fail low, wait, ordered shutdown
// - Overtemperature follows the same sequence
// - Automatic restart once fault clears
// - Charger lockout at about 2.5 V
// - Order pin picks first-up, last-down converter
// - Core default from strap, 1.5/1.8 V
// - Main default from strap, 3.0/3.3 V
// - Power fail low while reset low
// - Bit 7 forces fixed-frequency mode
// - Reset held through startup plus hold
`timescale 1ns/100ps
module pss_sequencer
    import pss_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    input  wire logic       seq_order_sel_i,
    input  wire logic       core_default_sel_i,
    input  wire logic       main_default_sel_i,
    input  wire logic       undervolt_i,
    input  wire logic       overtemp_i,
    input  wire logic       battery_lid_present_i,
    input  wire logic       high_load_i,
    input  wire logic       dropout_i,
    input  wire logic       charger_supply_low_i,
    input  wire logic [3:0] good_raw_i,
    output logic            main_en_o,
    output logic            core_en_o,
    output logic            ldo_one_en_o,
    output logic            ldo_two_en_o,
    output logic            main_disch_o,
    output logic            core_disch_o,
    output logic            fixed_freq_o,
    output logic            full_duty_o,
    output logic            charger_lockout_o,
    output logic      [3:0] main_vsel_o,
    output logic      [3:0] core_vsel_o,
    output logic      [2:0] undervolt_lockout_sel_o,
    output logic            power_fail_n_o,
    output logic            power_on_reset_n_o,
    output logic            irq_o
);
    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    localparam int NSYNC = 9;
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] pin_s1;
    logic [NSYNC-1:0] pin_s2;
    assign pin_raw = {seq_order_sel_i, core_default_sel_i, main_default_sel_i, undervolt_i, overtemp_i,
                      battery_lid_present_i, high_load_i, dropout_i, charger_supply_low_i};
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
        end else begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
        end
    end
    logic order_s, coredef_s, maindef_s, uv_s, ot_s, lid_s, hiload_s, drop_s, chg_low_s;
    assign {order_s, coredef_s, maindef_s, uv_s, ot_s, lid_s, hiload_s, drop_s, chg_low_s} = pin_s2;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] buck_ctrl_a, next_buck_ctrl_a;
    logic [7:0] buck_ctrl_b, next_buck_ctrl_b;
    logic [7:0] ldo_ctrl, next_ldo_ctrl;
    logic [2:0] undervolt_lockout_ctrl, next_undervolt_lockout_ctrl;
    logic [3:0] event_flags, next_event_flags;
    logic [3:0] event_mask, next_event_mask;
    logic [7:0] rdata, next_rdata;
    logic       strap_done, next_strap_done;
    logic [1:0] strap_wait, next_strap_wait;
    logic [3:0] rail_good;
    logic [3:0] rail_fall;
    logic [3:0] rail_en;

    // Straps are caught only once the synchroniser holds real pin levels, never under reset
    always_comb begin
        next_buck_ctrl_a = buck_ctrl_a;
        next_buck_ctrl_b = buck_ctrl_b;
        next_ldo_ctrl    = ldo_ctrl;
        next_undervolt_lockout_ctrl   = undervolt_lockout_ctrl;
        next_event_mask  = event_mask;
        next_strap_wait  = {strap_wait[0], 1'b1};
        next_strap_done  = strap_done | strap_wait[1];
        if (!strap_done) begin
            next_buck_ctrl_a[BA_VSEL_LSB +: BA_VSEL_W] = maindef_s ? MAIN_3V3 : MAIN_3V0;
            next_buck_ctrl_b[BB_VSEL_LSB +: BB_VSEL_W] = coredef_s ? CORE_1V8 : CORE_1V5;
        end
        if (wr_i) begin
            unique case (addr_i)
                ADDR_BUCK_CTRL_A: next_buck_ctrl_a = wdata_i;
                ADDR_BUCK_CTRL_B: next_buck_ctrl_b = wdata_i;
                ADDR_LDO_CTRL:    next_ldo_ctrl    = wdata_i;
                ADDR_UNDERVOLT_LOCKOUT_CTRL:   next_undervolt_lockout_ctrl   = wdata_i[2:0];
                ADDR_EVENT_MASK:  next_event_mask  = wdata_i[3:0];
                default:          ;
            endcase
        end
        // Write one to clear; a drop in the same cycle wins
        next_event_flags = event_flags;
        if (wr_i && addr_i == ADDR_EVENT_FLAGS) begin
            next_event_flags = event_flags & ~wdata_i[3:0];
        end
        next_event_flags = next_event_flags | rail_fall;
        next_rdata = 8'h00;
        if (rd_i) begin
            unique case (addr_i)
                ADDR_BUCK_CTRL_A: next_rdata = buck_ctrl_a;
                ADDR_BUCK_CTRL_B: next_rdata = buck_ctrl_b;
                ADDR_LDO_CTRL:    next_rdata = ldo_ctrl;
                ADDR_UNDERVOLT_LOCKOUT_CTRL:   next_rdata = {5'h00, undervolt_lockout_ctrl};
                ADDR_REG_STATUS:  next_rdata = {4'h0, rail_good};
                ADDR_EVENT_FLAGS: next_rdata = {4'h0, event_flags};
                ADDR_EVENT_MASK:  next_rdata = {4'h0, event_mask};
                default:          next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            buck_ctrl_a <= 8'h00;
            buck_ctrl_b <= 8'h00;
            ldo_ctrl    <= LDO_CTRL_RST;
            undervolt_lockout_ctrl   <= UNDERVOLT_LOCKOUT_2V75;
            event_flags <= 4'h0;
            event_mask  <= MASK_RST;
            rdata       <= 8'h00;
            strap_done  <= 1'b0;
            strap_wait  <= 2'h0;
        end else begin
            buck_ctrl_a <= next_buck_ctrl_a;
            buck_ctrl_b <= next_buck_ctrl_b;
            ldo_ctrl    <= next_ldo_ctrl;
            undervolt_lockout_ctrl   <= next_undervolt_lockout_ctrl;
            event_flags <= next_event_flags;
            event_mask  <= next_event_mask;
            rdata       <= next_rdata;
            strap_done  <= next_strap_done;
            strap_wait  <= next_strap_wait;
        end
    end

    // ------------------------------------------------------------------
    // Rail monitors
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NRAIL; gi++) begin : g_mon
            pss_rail_mon u_mon (
                .clock_i    (clock_i),
                .rst_i      (rst_i),
                .enable_i   (rail_en[gi]),
                .good_raw_i (good_raw_i[gi]),
                .good_o     (rail_good[gi]),
                .fall_o     (rail_fall[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    pss_state_type state, next_state;
    logic [CNT_W-1:0] cnt, next_cnt;
    logic fixed_freq;
    logic fault;
    logic first_en, second_en;
    logic next_first_en, next_second_en;
    logic main_en, core_en;
    logic lid_seen, next_lid_seen;

    assign fixed_freq = buck_ctrl_a[BA_FORCE_FF] | hiload_s;
    // Thermal trip only counts while switching at fixed frequency
    assign fault = uv_s | (ot_s & fixed_freq) | (lid_seen & ~lid_s);
    // First converter is core when order pin low, main when high
    assign main_en = order_s ? first_en : second_en;
    assign core_en = order_s ? second_en : first_en;
    assign rail_en = {ldo_ctrl[LC_EN_TWO] & main_en, ldo_ctrl[LC_EN_ONE] & main_en, core_en, main_en};

    always_comb begin
        next_state     = state;
        next_cnt       = cnt;
        next_first_en  = first_en;
        next_second_en = second_en;
        next_lid_seen  = lid_seen | lid_s;
        unique case (state)
            PSS_OFF: begin
                if (strap_done && !fault) begin
                    next_state    = PSS_UP1;
                    next_first_en = 1'b1;
                    next_cnt      = CNT_W'(SEQ_GAP_CYC);
                end
            end
            PSS_UP1: begin
                if (fault) begin
                    next_state = PSS_LOCK;
                    next_cnt   = CNT_W'(UNDERVOLT_LOCKOUT_DELAY_CYC);
                end else if (cnt == '0) begin
                    next_state     = PSS_UP2;
                    next_second_en = 1'b1;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            PSS_UP2: begin
                next_state = PSS_RUN;
            end
            PSS_RUN: begin
                if (fault) begin
                    next_state = PSS_LOCK;
                    next_cnt   = uv_s ? CNT_W'(UNDERVOLT_LOCKOUT_DELAY_CYC) : CNT_W'(OT_DELAY_CYC);
                end
            end
            PSS_LOCK: begin
                if (cnt == '0) begin
                    next_state     = PSS_DN1;
                    next_second_en = 1'b0;
                    next_cnt       = CNT_W'(SEQ_GAP_CYC);
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            PSS_DN1: begin
                if (cnt == '0) begin
                    next_state    = PSS_DN2;
                    next_first_en = 1'b0;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            PSS_DN2: begin
                next_state = PSS_OFF;
            end
            default: begin
                next_state = PSS_OFF;
            end
        endcase
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state     <= PSS_OFF;
            cnt       <= '0;
            first_en  <= 1'b0;
            second_en <= 1'b0;
            lid_seen  <= 1'b0;
        end else begin
            state     <= next_state;
            cnt       <= next_cnt;
            first_en  <= next_first_en;
            second_en <= next_second_en;
            lid_seen  <= next_lid_seen;
        end
    end

    // ------------------------------------------------------------------
    // Reset hold and outputs
    // ------------------------------------------------------------------
    logic [CNT_W-1:0] por_cnt, next_por_cnt;
    logic por_n, next_por_n;
    logic pf_n, next_pf_n;
    logic [23:0] outs, next_outs;

    always_comb begin
        next_por_cnt = por_cnt;
        next_por_n   = por_n;
        if (!rail_good[0]) begin
            next_por_cnt = CNT_W'(POR_HOLD_CYC);
            next_por_n   = 1'b0;
        end else if (por_cnt != '0) begin
            next_por_cnt = por_cnt - 1'b1;
        end else begin
            next_por_n = 1'b1;
        end
        next_pf_n = next_por_n & ~fault & (state != PSS_LOCK);
        next_outs = {main_en, core_en, rail_en[2], rail_en[3],
                     ~main_en & (state != PSS_RUN) & buck_ctrl_a[BA_DISCH],
                     ~core_en & (state != PSS_RUN) & buck_ctrl_b[BB_DISCH],
                     fixed_freq, drop_s,
                     chg_low_s,
                     buck_ctrl_a[3:0], buck_ctrl_b[3:0], undervolt_lockout_ctrl,
                     |(event_flags & event_mask), 3'h0};
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            por_cnt <= '0;
            por_n   <= 1'b0;
            pf_n    <= 1'b0;
            outs    <= '0;
        end else begin
            por_cnt <= next_por_cnt;
            por_n   <= next_por_n;
            pf_n    <= next_pf_n;
            outs    <= next_outs;
        end
    end

    assign {main_en_o, core_en_o, ldo_one_en_o, ldo_two_en_o, main_disch_o, core_disch_o, fixed_freq_o,
            full_duty_o, charger_lockout_o, main_vsel_o, core_vsel_o, undervolt_lockout_sel_o, irq_o} = outs[23:3];
    assign rdata_o            = rdata;
    assign power_on_reset_n_o = por_n;
    assign power_fail_n_o     = pf_n;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    por_fail_link_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !power_on_reset_n_o |-> !power_fail_n_o) else $error("power fail high while reset low");
    por_needs_good_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !rail_good[0] |=> !power_on_reset_n_o) else $error("reset released without main good");
    lock_drops_fail_a: assert property (@(posedge clock_i) disable iff (rst_i)
        state == PSS_LOCK |=> !power_fail_n_o) else $error("power fail not low in lockout");
    order_down_a: assert property (@(posedge clock_i) disable iff (rst_i)
        state == PSS_DN1 |-> first_en && !second_en) else $error("shutdown order wrong");
    ldo_reset_on_a: assert property (@(posedge clock_i) disable iff (rst_i)
        $rose(strap_done) |-> ldo_ctrl[LC_EN_ONE] && ldo_ctrl[LC_EN_TWO]) else $error("ldo off after reset");
    mon_off_quiet_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !rail_en[1] ##1 !rail_en[1] |-> !rail_good[1] && !rail_fall[1]) else $error("off core monitored");
    fall_sets_flag_a: assert property (@(posedge clock_i) disable iff (rst_i)
        rail_fall[0] |=> event_flags[0]) else $error("drop event lost");
    restart_auto_a: assert property (@(posedge clock_i) disable iff (rst_i)
        state == PSS_OFF && strap_done && !fault |=> state == PSS_UP1) else $error("no restart");
endmodule : pss_sequencer

// File: src/pss_pkg.sv
/*
 * Constants for the supervisor and sequencer: register map, field positions,
 * reset values, voltage codes and timing counts.
 * Assumes a 40 MHz logic clock and a simple strobe register port.
 */
package pss_pkg;
    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ            = 40_000_000;
    localparam int UNDERVOLT_LOCKOUT_DELAY_US     = 100;
    localparam int OT_DELAY_US       = 100;
    localparam int SEQ_GAP_US        = 50;
    localparam int POR_HOLD_US       = 1000;
    localparam int UNDERVOLT_LOCKOUT_DELAY_CYC    = UNDERVOLT_LOCKOUT_DELAY_US * (CLK_HZ / 1_000_000);
    localparam int OT_DELAY_CYC      = OT_DELAY_US * (CLK_HZ / 1_000_000);
    localparam int SEQ_GAP_CYC       = SEQ_GAP_US * (CLK_HZ / 1_000_000);
    localparam int POR_HOLD_CYC      = POR_HOLD_US * (CLK_HZ / 1_000_000);
    localparam int CNT_W             = 16;

    // ------------------------------------------------------------------
    // Register map (byte offsets)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_BUCK_CTRL_A  = 8'h00;
    localparam logic [7:0] ADDR_BUCK_CTRL_B  = 8'h04;
    localparam logic [7:0] ADDR_LDO_CTRL     = 8'h08;
    localparam logic [7:0] ADDR_UNDERVOLT_LOCKOUT_CTRL    = 8'h0C;
    localparam logic [7:0] ADDR_REG_STATUS   = 8'h10;
    localparam logic [7:0] ADDR_EVENT_FLAGS  = 8'h14;
    localparam logic [7:0] ADDR_EVENT_MASK   = 8'h18;

    // buck_ctrl_a fields
    localparam int BA_VSEL_LSB  = 0;
    localparam int BA_VSEL_W    = 4;
    localparam int BA_DISCH     = 5;
    localparam int BA_FORCE_FF  = 7;
    // buck_ctrl_b fields
    localparam int BB_VSEL_LSB  = 0;
    localparam int BB_VSEL_W    = 4;
    localparam int BB_DISCH     = 5;
    // ldo_ctrl fields
    localparam int LC_EN_ONE    = 0;
    localparam int LC_EN_TWO    = 1;
    localparam int LC_VSEL_LSB  = 4;
    localparam int LC_VSEL_W    = 4;
    // event bits: 0 main, 1 core, 2 ldo one, 3 ldo two
    localparam int NRAIL        = 4;

    // ------------------------------------------------------------------
    // Reset values and voltage codes
    // ------------------------------------------------------------------
    localparam logic [7:0] LDO_CTRL_RST  = 8'h03;
    localparam logic [2:0] UNDERVOLT_LOCKOUT_2V75     = 3'h3;
    localparam logic [3:0] MAIN_3V0      = 4'h6;
    localparam logic [3:0] MAIN_3V3      = 4'h7;
    localparam logic [3:0] CORE_1V5      = 4'h8;
    localparam logic [3:0] CORE_1V8      = 4'hB;
    localparam logic [3:0] MASK_RST      = 4'hF;

    typedef enum logic [2:0] {
        PSS_OFF    = 3'b000,
        PSS_UP1    = 3'b001,
        PSS_UP2    = 3'b011,
        PSS_RUN    = 3'b010,
        PSS_LOCK   = 3'b110,
        PSS_DN1    = 3'b111,
        PSS_DN2    = 3'b101
    } pss_state_type;
endpackage : pss_pkg

// File: src/pss_rail_mon.sv
/*
 * Power-good monitor for one rail: synchronises the comparator,
 * applies the enable gate and produces a falling-edge event.
 * Assumes the analog comparator already implements the hysteresis band.
 */
`timescale 1ns/100ps
module pss_rail_mon
    import pss_pkg::*;
(
    input  wire logic clock_i,
    input  wire logic rst_i,
    input  wire logic enable_i,
    input  wire logic good_raw_i,
    output logic      good_o,
    output logic      fall_o
);
    logic sync_a;
    logic sync_b;
    logic good;
    logic next_good;
    logic fall;
    logic next_fall;

    // Monitoring is off with the rail, so an off rail reads not good but raises nothing
    always_comb begin
        next_good = enable_i & sync_b;
        next_fall = enable_i & good & ~sync_b;
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            good   <= 1'b0;
            fall   <= 1'b0;
        end else begin
            sync_a <= good_raw_i;
            sync_b <= sync_a;
            good   <= next_good;
            fall   <= next_fall;
        end
    end

    assign good_o = good;
    assign fall_o = fall;
endmodule : pss_rail_mon

// File: sim/pss_rail_model.sv
/*
 * Behavioural model of the four regulator stages and their power-good comparators.
 * Assumes the enables come from the sequencer and the bench injects rail drops.
 */
`timescale 1ns/100ps
module pss_rail_model (
    input  wire logic       clock_i,
    input  wire logic [3:0] en_i,
    input  wire logic [3:0] drop_i,
    output logic      [3:0] good_raw_o
);
    // ------------------------------------------------------------------
    // Ramp and comparator
    // ------------------------------------------------------------------
    logic [2:0] ramp [4];

    // A rail needs seven cycles to reach regulation; an off rail reads not good
    always @(posedge clock_i) begin
        for (int i = 0; i < 4; i++) begin
            if (!en_i[i]) begin
                ramp[i] <= 3'h0;
            end else if (ramp[i] != 3'h7) begin
                ramp[i] <= ramp[i] + 3'h1;
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            good_raw_o[i] = en_i[i] && !drop_i[i] && (ramp[i] == 3'h7);
        end
    end
endmodule : pss_rail_model

// File: sim/tb_pss_sequencer.sv
/*
 * Self-checking bench for the supervisor and sequencer.
 * Assumes the package timing constants as shipped and the rail model beside it.
 */
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected %0t: got %h want %h", $time, g, e); end end
`define WAIT(c, lim) for (n = 0; n < (lim) && !(c); n++) begin @(posedge clock_i); #1; end
module tb_pss_sequencer
    import pss_pkg::*;
;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic       clock_i, rst_i, wr_i, rd_i, undervolt_i, high_load_i, dropout_i, charger_supply_low_i, overtemp_i;
    logic [7:0] addr_i, wdata_i, rdata_o, d;
    logic [3:0] good_raw_i, drop, main_vsel_o, core_vsel_o;
    logic [2:0] undervolt_lockout_sel_o;
    logic       main_en_o, core_en_o, ldo_one_en_o, ldo_two_en_o, main_disch_o, core_disch_o;
    logic       fixed_freq_o, full_duty_o, charger_lockout_o, power_fail_n_o, power_on_reset_n_o, irq_o;
    int         fail_count = 0;
    int         tests_run = 0;
    int         n;
    typedef struct { logic [7:0] a; logic [7:0] wd; logic w; logic [7:0] e; } pss_row_type;
    pss_row_type rows [7] = '{'{ADDR_LDO_CTRL, 8'h00, 1'b0, 8'h03}, '{ADDR_UNDERVOLT_LOCKOUT_CTRL, 8'h00, 1'b0, 8'h03},
        '{ADDR_UNDERVOLT_LOCKOUT_CTRL, 8'h05, 1'b1, 8'h00}, '{ADDR_UNDERVOLT_LOCKOUT_CTRL, 8'h00, 1'b0, 8'h05},
        '{8'h20, 8'h00, 1'b0, 8'h00}, '{ADDR_BUCK_CTRL_A, 8'hA7, 1'b1, 8'h00},
        '{ADDR_REG_STATUS, 8'h00, 1'b0, 8'h0F}};

    pss_sequencer u_dut (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .seq_order_sel_i(1'b0), .core_default_sel_i(1'b0),
        .main_default_sel_i(1'b1), .undervolt_i(undervolt_i), .overtemp_i(overtemp_i),
        .battery_lid_present_i(1'b1),
        .high_load_i(high_load_i), .dropout_i(dropout_i), .charger_supply_low_i(charger_supply_low_i),
        .good_raw_i(good_raw_i), .main_en_o(main_en_o), .core_en_o(core_en_o), .ldo_one_en_o(ldo_one_en_o),
        .ldo_two_en_o(ldo_two_en_o), .main_disch_o(main_disch_o), .core_disch_o(core_disch_o),
        .fixed_freq_o(fixed_freq_o), .full_duty_o(full_duty_o), .charger_lockout_o(charger_lockout_o),
        .main_vsel_o(main_vsel_o), .core_vsel_o(core_vsel_o), .undervolt_lockout_sel_o(undervolt_lockout_sel_o),
        .power_fail_n_o(power_fail_n_o), .power_on_reset_n_o(power_on_reset_n_o), .irq_o(irq_o));

    pss_rail_model u_rails (.clock_i(clock_i), .en_i({ldo_two_en_o, ldo_one_en_o, core_en_o, main_en_o}),
        .drop_i(drop), .good_raw_o(good_raw_i));

    // ------------------------------------------------------------------
    // Clock, bus tasks, verdict
    // ------------------------------------------------------------------
    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end

    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock_i);
        addr_i <= a; wdata_i <= v; wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clock_i);
        addr_i <= a; rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask : rd

    task conclude;
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    // Power-up alone takes over 42000 cycles, so the limit sits well above it
    initial begin
        repeat (80000) @(posedge clock_i);
        fail_count++;
        conclude();
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        rst_i = 1'b1; wr_i = 1'b0; rd_i = 1'b0; addr_i = 8'h00; wdata_i = 8'h00; drop = 4'h0;
        undervolt_i = 1'b0; high_load_i = 1'b0; dropout_i = 1'b0; charger_supply_low_i = 1'b0; overtemp_i = 1'b0;
        repeat (10) @(posedge clock_i);
        rst_i <= 1'b0;
        // Straps pass the synchroniser, are caught, then reach the output register
        repeat (5) @(posedge clock_i); #1;
        `CHK(main_vsel_o, MAIN_3V3)
        `CHK(core_vsel_o, CORE_1V5)
        `WAIT(core_en_o === 1'b1, 100)
        `CHK(main_en_o, 1'b0)
        `WAIT(main_en_o === 1'b1, 3000)
        `CHK(n > 1900 && n < 3000, 1'b1)
        repeat (30000) @(posedge clock_i); #1;
        `CHK(power_on_reset_n_o, 1'b0)
        `CHK(power_fail_n_o, 1'b0)
        `WAIT(power_on_reset_n_o === 1'b1, 15000)
        `CHK(power_on_reset_n_o, 1'b1)
        `CHK(ldo_one_en_o & ldo_two_en_o, 1'b1)
        foreach (rows[i]) begin
            if (rows[i].w) wr(rows[i].a, rows[i].wd);
            else begin
                rd(rows[i].a, d);
                `CHK(d, rows[i].e)
            end
        end
        @(posedge clock_i); #1;
        `CHK(fixed_freq_o, 1'b1)
        `CHK(undervolt_lockout_sel_o, 3'h5)
        // Drop, clear, mask, then disable the second linear rail
        @(posedge clock_i) drop <= 4'h8;
        `WAIT(irq_o === 1'b1, 20)
        `CHK(irq_o, 1'b1)
        rd(ADDR_REG_STATUS, d);
        `CHK(d, 8'h07)
        @(posedge clock_i) drop <= 4'h0;
        wr(ADDR_EVENT_FLAGS, 8'h08);
        repeat (10) @(posedge clock_i); #1;
        `CHK(irq_o, 1'b0)
        wr(ADDR_EVENT_MASK, 8'h07);
        @(posedge clock_i) drop <= 4'h8;
        repeat (10) @(posedge clock_i); #1;
        `CHK(irq_o, 1'b0)
        rd(ADDR_EVENT_FLAGS, d);
        `CHK(d, 8'h08)
        @(posedge clock_i) drop <= 4'h0;
        wr(ADDR_EVENT_FLAGS, 8'h0F);
        wr(ADDR_EVENT_MASK, 8'h0F);
        wr(ADDR_LDO_CTRL, 8'h01);
        repeat (20) @(posedge clock_i); #1;
        `CHK(ldo_two_en_o, 1'b0)
        `CHK(irq_o, 1'b0)
        // Heat while switching in power save mode must not trip the supervisor
        wr(ADDR_BUCK_CTRL_A, 8'h27);
        @(posedge clock_i) overtemp_i <= 1'b1;
        repeat (8) @(posedge clock_i); #1;
        `CHK(power_fail_n_o, 1'b1)
        @(posedge clock_i) overtemp_i <= 1'b0;
        @(posedge clock_i) begin dropout_i <= 1'b1; charger_supply_low_i <= 1'b1; high_load_i <= 1'b1; end
        repeat (6) @(posedge clock_i); #1;
        `CHK(full_duty_o, 1'b1)
        `CHK(charger_lockout_o, 1'b1)
        // Undervoltage: fail low at once, ordered shutdown, restart
        @(posedge clock_i) undervolt_i <= 1'b1;
        `WAIT(power_fail_n_o === 1'b0, 10)
        `CHK(power_fail_n_o, 1'b0)
        repeat (3000) @(posedge clock_i); #1;
        `CHK(main_en_o, 1'b1)
        `WAIT(main_en_o === 1'b0, 2000)
        `CHK(core_en_o, 1'b1)
        `CHK(main_disch_o, 1'b1)
        `WAIT(core_en_o === 1'b0, 2500)
        `CHK(n > 1900 && n < 2500, 1'b1)
        `CHK(core_disch_o, 1'b0)
        rd(ADDR_EVENT_FLAGS, d);
        `CHK(d, 8'h00)
        @(posedge clock_i) undervolt_i <= 1'b0;
        `WAIT(core_en_o === 1'b1, 200)
        `CHK(core_en_o, 1'b1)
        conclude();
    end
endmodule : tb_pss_sequencer
